// file: pss_ctrl_model.sv
// controller model driving clock enables, selects, clock stop and programming
`timescale 1ns/1ps
module pss_ctrl_model
  import pss_pkg::*;
(
  input  wire logic    clock_in,
  output logic         cke0_out,
  output logic         cke1_out,
  output logic [3:0]   cs_out,
  output logic         stop_out,
  output logic         prog_out,
  output pss_ps_word_t word_out
);
  localparam int CKE_LOW_MIN = 5;
  int cyc     = 0;
  int last    = -PROG_SPACING_TCK;
  int low_cnt = 0;
  // powers up with enables low and selects high, ready for reset release
  initial begin
    cke0_out = 1'h0;
    cke1_out = 1'h0;
    cs_out   = 4'hf;
    stop_out = 1'h0;
    prog_out = 1'h0;
    word_out = PS_WORD_RESET;
  end
  // cycle count for access spacing, run length of both enables low
  always @(posedge clock_in) begin
    cyc     <= cyc + 1;
    low_cnt <= (cke0_out | cke1_out) ? 0 : low_cnt + 1;
  end
  task automatic drive_cke(input logic a, input logic b);
    @(posedge clock_in);
    cke0_out <= a;
    cke1_out <= b;
  endtask : drive_cke
  // waits out the spacing; data toggles once released so stale values never pass
  task automatic prog_word(input pss_ps_word_t w, input logic [3:0] cs);
    @(posedge clock_in);
    while (cyc - last < PROG_SPACING_TCK) @(posedge clock_in);
    last = cyc;
    cs_out   <= cs;
    prog_out <= 1'h1;
    word_out <= w;
    @(posedge clock_in);
    cs_out   <= 4'hf;
    prog_out <= 1'h0;
    word_out <= ~w;
  endtask : prog_word
  // clock may only stop after a long enough run of both enables low
  task automatic clock_stop(input logic s);
    @(posedge clock_in);
    while (s && low_cnt < CKE_LOW_MIN) @(posedge clock_in);
    stop_out <= s;
  endtask : clock_stop
endmodule : pss_ctrl_model

// file: pss_pkg.sv
// shared constants and types for the power-save cycle sequencer
package pss_pkg;

  // ----------------------------------------------------------------
  // clock and timing figures
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS        = 8000;  // 125 MHz
  localparam int INPUT_CLK_PERIOD_PS  = 8000;  // one input clock per local edge
  // figures in input clock periods (tCK), float figure held in half periods
  localparam int IN_OFF_MIN_TCK       = 1;
  localparam int IN_OFF_MAX_TCK       = 4;
  localparam int IN_OFF_USE_TCK       = 2;     // chosen inside the 1..4 window
  localparam int OUT_FLOAT_HALF_TCK   = 3;     // 1.5 tCK
  localparam int CKE_BUF_HOLD_TCK     = 2;     // least hold after clock stop
  localparam int STATIC_EXIT_MIN_TCK  = 1;
  localparam int STATIC_EXIT_MAX_TCK  = 3;
  localparam int STATIC_EXIT_USE_TCK  = 2;     // chosen inside the 1..3 window
  localparam int PRE_RESET_HOLD_TCK   = 8;
  localparam int PROG_SPACING_TCK     = 8;

  // derived cycle counts; half-period figure rounds up to whole cycles
  localparam int IN_OFF_CYC      = IN_OFF_USE_TCK * INPUT_CLK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int OUT_FLOAT_CYC   =
    (OUT_FLOAT_HALF_TCK * INPUT_CLK_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
  localparam int CKE_BUF_CYC     = CKE_BUF_HOLD_TCK * INPUT_CLK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int STATIC_EXIT_CYC = STATIC_EXIT_USE_TCK * INPUT_CLK_PERIOD_PS / CLK_PERIOD_PS;

  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // power saving control word as delivered by a programming access
  typedef struct packed {
    logic enable;   // power_save_enable_bit
    logic option;   // power_save_option_bit, no effect on timing
  } pss_ps_word_t;

  localparam pss_ps_word_t PS_WORD_RESET = '{enable: 1'b0, option: 1'b0};

  // buffer enables driven toward the pad ring
  typedef struct packed {
    logic input_buf;    // command/address input receivers
    logic output_buf;   // output drivers, low means high impedance
    logic cke_buf;      // clock-enable input receivers
  } pss_buf_en_t;

  localparam pss_buf_en_t BUF_ALL_ON = '{input_buf: 1'b1, output_buf: 1'b1, cke_buf: 1'b1};

  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_ENTRY = 3'h1,
    ST_SAVE  = 3'h2,
    ST_STOP  = 3'h3,
    ST_DEEP  = 3'h4,
    ST_EXIT  = 3'h5
  } pss_state_t;

endpackage : pss_pkg

// file: pss_sequencer.sv
// power-save entry, clock-stop and exit sequencer for the registering driver
`timescale 1ns/1ps

// Operation
// - with power saving on, inputs disable 1 to 4 cycles after both cke low
// - outputs float 1.5 cycles after cke outputs go low (here rounded up to 2 cycles)
// - cke receivers stay on at least 2 cycles after clock stops
// - static outputs return 1 to 3 cycles after either cke seen high (ST_STOP and ST_DEEP ignore cke until the clock restarts)
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int CS_W = 4
) (
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  input  wire logic              cke_in_rank0,
  input  wire logic              cke_in_rank1,
  input  wire logic [CS_W-1:0]   chip_select_inputs,
  input  wire logic              clock_stopped_in,
  input  wire logic              prog_valid_in,
  input  wire pss_ps_word_t      power_saving_control_word,
  output logic [1:0]             cke_outputs,
  output pss_buf_en_t            buf_en_out,
  output logic                   static_out_valid_out,
  output logic                   power_save_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pss_state_t           state_ff,   nxt_state;
  logic [CNT_W-1:0]     cnt_ff,     nxt_cnt;
  pss_ps_word_t         cfg_ff,     nxt_cfg;
  pss_buf_en_t          buf_ff,     nxt_buf;
  logic [1:0]           cke_out_ff, nxt_cke_out;
  logic                 static_ff,  nxt_static;
  logic                 save_ff,    nxt_save;
  logic                 cke_low;
  logic                 cs_idle;

  // every decision below uses values taken at the rising edge
  assign cke_low = ~cke_in_rank0 & ~cke_in_rank1;
  // all selects high: no command is in flight, so programming is safe
  assign cs_idle = &chip_select_inputs;

  // ----------------------------------------------------------------
  // control word capture
  // ----------------------------------------------------------------
  // programming is only taken while running with no select asserted; the
  // controller is trusted to keep accesses spaced, so no spacing check here
  always_comb begin
    nxt_cfg = cfg_ff;
    if (prog_valid_in && (state_ff == ST_RUN) && cs_idle) begin
      nxt_cfg = power_saving_control_word;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one shared counter: each state restarts it on entry
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff + CNT_ONE;
    nxt_buf     = buf_ff;
    nxt_cke_out = cke_out_ff;
    nxt_static  = static_ff;
    nxt_save    = save_ff;
    case (state_ff)
      ST_RUN: begin
        nxt_cnt     = CNT_ZERO;
        nxt_buf     = BUF_ALL_ON;
        nxt_static  = 1'b1;
        nxt_save    = 1'b0;
        nxt_cke_out = {cke_in_rank1, cke_in_rank0};
        if (cfg_ff.enable && cke_low) begin
          nxt_state = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        nxt_static = 1'b0;
        nxt_save   = 1'b1;
        if (!cke_low) begin
          // cke came back before the sequence finished: leave cleanly
          nxt_state = ST_EXIT;
          nxt_cnt   = CNT_ZERO;
        end else begin
          if (cnt_ff == CNT_W'(IN_OFF_CYC - 1)) begin
            nxt_buf.input_buf = 1'b0;
          end
          if (cnt_ff == CNT_W'(OUT_FLOAT_CYC - 1)) begin
            nxt_buf.output_buf = 1'b0;
          end
          if (cnt_ff >= CNT_W'((IN_OFF_CYC > OUT_FLOAT_CYC ? IN_OFF_CYC : OUT_FLOAT_CYC) - 1))
          begin
            nxt_state = ST_SAVE;
          end
        end
      end
      ST_SAVE: begin
        nxt_cnt = CNT_ZERO;
        if (!cke_low) begin
          nxt_state = ST_EXIT;
        end else if (clock_stopped_in) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // receivers held on for the minimum after the clock goes low
        if (!clock_stopped_in) begin
          nxt_state = ST_SAVE;
        end else if (cnt_ff == CNT_W'(CKE_BUF_CYC - 1)) begin
          nxt_buf.cke_buf = 1'b0;
          nxt_state       = ST_DEEP;
        end
      end
      ST_DEEP: begin
        nxt_cnt = CNT_ZERO;
        // limitation: with cke receivers off only the clock restart can wake us
        if (!clock_stopped_in) begin
          nxt_buf.cke_buf = 1'b1;
          nxt_state       = ST_SAVE;
        end
      end
      ST_EXIT: begin
        nxt_buf.input_buf = 1'b1;
        if (cnt_ff == CNT_W'(STATIC_EXIT_CYC - 1)) begin
          nxt_buf     = BUF_ALL_ON;
          nxt_static  = 1'b1;
          nxt_save    = 1'b0;
          nxt_cke_out = {cke_in_rank1, cke_in_rank0};
          nxt_state   = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
        nxt_cnt   = CNT_ZERO;
      end
    endcase
    // every state change restarts the shared counter
    if (nxt_state != state_ff) begin
      nxt_cnt = CNT_ZERO;
    end
    // cke outputs drop with the entry edge so the float delay counts from there
    if (nxt_state == ST_ENTRY) begin
      nxt_cke_out = 2'h0;
    end
  end

  // registers only; all selection is done in the processes above
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff   <= ST_RUN;
      cnt_ff     <= CNT_ZERO;
      cfg_ff     <= PS_WORD_RESET;
      buf_ff     <= BUF_ALL_ON;
      cke_out_ff <= 2'h0;
      static_ff  <= 1'b0;
      save_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      cfg_ff     <= nxt_cfg;
      buf_ff     <= nxt_buf;
      cke_out_ff <= nxt_cke_out;
      static_ff  <= nxt_static;
      save_ff    <= nxt_save;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cke_outputs          = cke_out_ff;
  assign buf_en_out           = buf_ff;
  assign static_out_valid_out = static_ff;
  assign power_save_out       = save_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_input_buf_off: assert property (
    (state_ff == ST_RUN && cfg_ff.enable && cke_low) ##1 cke_low[*3]
      |-> ##[0:3] !buf_ff.input_buf)
    else $error("input buffers not disabled within 4 cycles of cke low");

  a_disabled_stays: assert property (
    (state_ff == ST_RUN && !cfg_ff.enable) |=> state_ff == ST_RUN)
    else $error("power save entered while disabled");

  a_output_float: assert property (
    (state_ff == ST_ENTRY && $fell(|cke_out_ff)) ##1 cke_low |-> ##1 !buf_ff.output_buf)
    else $error("outputs not floated after cke outputs went low");

  a_cke_buf_hold: assert property (
    $rose(state_ff == ST_STOP) |-> buf_ff.cke_buf[*2])
    else $error("cke receivers disabled too early after clock stop");

  a_static_exit: assert property (
    (state_ff == ST_SAVE && !cke_low) |-> ##[1:3] static_ff)
    else $error("static outputs not restored within 3 cycles");

  a_edge_sample: assert property (
    (state_ff == ST_RUN && !(cfg_ff.enable && cke_low))
      |=> cke_out_ff == {$past(cke_in_rank1), $past(cke_in_rank0)})
    else $error("cke outputs do not follow sampled inputs");

  a_prog_refused: assert property (
    (prog_valid_in && !cs_idle) |=> $stable(cfg_ff))
    else $error("control word taken while a select was low");

  a_save_quiet: assert property (
    (state_ff == ST_SAVE) |-> (!buf_ff.input_buf && !buf_ff.output_buf && cke_out_ff == 2'h0))
    else $error("buffers or cke outputs active in power save");

  a_cke_buf_wake: assert property (
    (state_ff == ST_DEEP && !clock_stopped_in) |=> buf_ff.cke_buf)
    else $error("cke receivers not restored on clock restart");

  c_deep_reached: cover property (state_ff == ST_DEEP);
  c_exit_done:    cover property (state_ff == ST_EXIT ##[1:3] state_ff == ST_RUN);
  c_entry_abort:  cover property (state_ff == ST_ENTRY ##1 state_ff == ST_EXIT);
  c_save_reached: cover property (state_ff == ST_ENTRY ##1 state_ff == ST_SAVE);

endmodule : pss_sequencer

// file: tb_power_save_cycle_timing.sv
// self-checking bench for the power-save sequencer
`timescale 1ns/1ps
module tb_power_save_cycle_timing;
  import pss_pkg::*;
  logic         clock_in = 1'h0;
  logic         rst_n_in = 1'h0;
  logic         c0, c1, stp, pv, sv, ps;
  logic [3:0]   cs;
  logic [1:0]   cke_q;
  pss_ps_word_t w;
  pss_buf_en_t  be;
  int           fail_count = 0;
  int           checks_done = 0;
  int           cycles = 0;
  int           n_a, n_b;
  logic [31:0]  seed = 32'h4f;
  initial forever #4 clock_in = ~clock_in;
  pss_ctrl_model ctrl (.clock_in(clock_in), .cke0_out(c0), .cke1_out(c1), .cs_out(cs),
    .stop_out(stp), .prog_out(pv), .word_out(w));
  pss_sequencer dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .cke_in_rank0(c0),
    .cke_in_rank1(c1), .chip_select_inputs(cs), .clock_stopped_in(stp),
    .prog_valid_in(pv), .power_saving_control_word(w), .cke_outputs(cke_q),
    .buf_en_out(be), .static_out_valid_out(sv), .power_save_out(ps));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic in_win(input int n, input int lo, input int hi);
    return n >= lo && n <= hi;
  endfunction : in_win
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // sample just after the edge so its register updates have landed
  task automatic step;
    @(posedge clock_in);
    #1;
  endtask : step
  // first edge at which each chosen output bit reaches lvl, over a fixed look
  task automatic watch(input int sa, input int sb, input logic lvl, output int na, output int nb);
    logic [3:0] v;
    na = 99;
    nb = 99;
    for (int i = 1; i <= 8; i++) begin
      step;
      v = {be, sv};
      if (na == 99 && v[sa] === lvl) na = i;
      if (nb == 99 && v[sb] === lvl) nb = i;
    end
  endtask : watch
  task automatic exit_chk(input logic a, input logic b);
    ctrl.drive_cke(a, b);
    watch(0, 3, 1'h1, n_a, n_b);
    chk("static_exit", 8'h1, {7'h0, in_win(n_a - 1, 1, STATIC_EXIT_MAX_TCK)});
    chk("awake", {1'h0, b, a, BUF_ALL_ON, 2'h2}, {1'h0, cke_q, be, sv, ps});
  endtask : exit_chk
  // hang guard, far above the roughly 170 cycles the sequence needs
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      close_out;
    end
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (PRE_RESET_HOLD_TCK) @(posedge clock_in);
    chk("rst", {1'h0, 2'h0, BUF_ALL_ON, 2'h0}, {1'h0, cke_q, be, sv, ps});
    rst_n_in <= 1'h1;
    step;
    chk("static_run", 8'h1, {7'h0, sv});
    // power saving off: enables pass straight through, never entering save
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      ctrl.drive_cke(seed[0], seed[1]);
      step;
      chk("cke_follow", {6'h0, seed[1], seed[0]}, {6'h0, cke_q});
      chk("no_save", 8'h0, {7'h0, ps});
    end
    // access with a select low must be ignored
    ctrl.prog_word('{enable: 1'h1, option: 1'h0}, 4'he);
    ctrl.drive_cke(1'h0, 1'h0);
    repeat (6) step;
    chk("refused", 8'h0, {7'h0, ps});
    for (int opt = 0; opt < 2; opt++) begin
      seed = xs(seed);
      // enables raised before the word lands, so entry starts only on the drop
      ctrl.drive_cke(1'h1, 1'h1);
      ctrl.prog_word('{enable: 1'h1, option: opt[0]}, 4'hf);
      ctrl.drive_cke(1'h0, 1'h0);
      watch(3, 2, 1'h0, n_a, n_b);
      chk("in_off", 8'h1, {7'h0, in_win(n_a - 1, IN_OFF_MIN_TCK, IN_OFF_MAX_TCK)});
      chk("out_float", 8'(OUT_FLOAT_CYC), 8'(n_b - 1));
      chk("save", 8'h1, {4'h0, cke_q, sv, ps});
      ctrl.clock_stop(1'h1);
      watch(1, 1, 1'h0, n_a, n_b);
      chk("cke_buf_hold", 8'h1, {7'h0, in_win(n_a, CKE_BUF_HOLD_TCK, 8)});
      ctrl.clock_stop(1'h0);
      watch(1, 1, 1'h1, n_a, n_b);
      chk("cke_buf_wake", 8'h1, {7'h0, in_win(n_a, 1, 2)});
      exit_chk(seed[0], ~seed[0]);
    end
    // enables rise again on the same edge that starts entry
    ctrl.drive_cke(1'h0, 1'h0);
    exit_chk(1'h1, 1'h1);
    close_out;
  end
endmodule : tb_power_save_cycle_timing
